/* hdl/ddr4_regs.svh */
// register offsets, field positions, reset values, command codes and counts
// assumes: included by bare name from the package, the assertion checker and the bench
`ifndef DDR4_REGS_SVH
`define DDR4_REGS_SVH

// ------------------------------------------------------------------
// register map, byte addresses on the plain register port
// ------------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_MR3 8'h08
`define OFF_MR4 8'h0C
`define OFF_MR5 8'h10
`define OFF_BURSTS 8'h14
`define CTRL_RESET 3'h4
`define CTRL_ORG_LSB 0
`define CTRL_CHECK_BIT 2
`define ST_READY_BIT 0
`define ST_ERR_LSB 1
`define ST_OPEN_LSB 16

// ------------------------------------------------------------------
// mode register fields and power-up defaults
// ------------------------------------------------------------------
`define MR_RESET 14'h0000
`define MR0_BL_LSB 0
`define MR0_BT_BIT 3
`define MR3_GEARDOWN_BIT 3
`define MR3_PDA_BIT 4
`define MR4_MAXPD_BIT 1
`define MR4_SPPR_BIT 5
`define MR4_CAL_LSB 6
`define MR4_HPPR_BIT 13
`define MR5_PAR_LSB 0

// ------------------------------------------------------------------
// command codes on {ras, cas, we} = address 16..14, burst codes, counts
// ------------------------------------------------------------------
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_ZQ 3'h6
`define CMD_NOP 3'h7
`define BL_OTF 2'h1
`define BL_FIX4 2'h2
`define ADDR_AP_BIT 10
`define ADDR_BL8_BIT 12
`define XPR_CYCLES 5

`endif

/* hdl/ddr4_pkg.sv */
// types shared by the device core and its helpers
// assumes: nothing beyond the constants header
package ddr4_pkg;
  `include "ddr4_regs.svh"

  typedef enum logic [2:0] {
    INIT_WAIT_CKE = 3'b001,
    INIT_XPR = 3'b010,
    INIT_READY = 3'b100
  } init_state_t;

  typedef enum logic [1:0] {
    ORG_X4 = 2'h0,
    ORG_X8 = 2'h1,
    ORG_X16 = 2'h2
  } org_t;

  typedef struct packed {
    logic cke;
    logic cs_n;
    logic act_n;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
  } link_pins_t;

  typedef struct packed {
    logic write;
    logic bc4;
    logic interleave;
    logic [3:0] bank;
    logic [9:0] col;
  } burst_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic last;
    logic [3:0] bank;
    logic [9:0] col_even;
    logic [9:0] col_odd;
  } beat_t;

  typedef struct packed {
    logic ready;
    logic [15:0] open_mask;
    logic [13:0] mr3;
    logic [13:0] mr4;
    logic [13:0] mr5;
    logic [15:0] bursts;
  } snap_t;
endpackage

/* hdl/cdc_sync.sv */
// two-flop synchroniser for levels and toggles
// assumes: each bit crosses on its own; words need a handshake around it
`timescale 1ns/100ps
module cdc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;
  sync_state_t s;
  sync_state_t next_s;

  always_comb begin
    next_s.s1 = d;
    next_s.s2 = s.s1;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign q = s.s2;
endmodule

/* hdl/burst_gen.sv */
// column sequencer: two data words per link clock, bursts of eight or four
// assumes: start is a one-cycle pulse on ck; a new start cuts off a running burst
`timescale 1ns/100ps
module burst_gen (
  input wire logic ck,
  input wire logic rst_n,
  input wire logic start,
  input ddr4_pkg::burst_req_t req,
  output ddr4_pkg::beat_t beat
);
  import ddr4_pkg::*;

  typedef struct packed {
    burst_req_t cur;
    logic [2:0] idx;
    logic busy;
    beat_t beat;
  } gen_state_t;
  gen_state_t s;
  gen_state_t next_s;

  // sequential wraps inside a nibble, interleaved xors the start column
  function automatic logic [9:0] col_of(burst_req_t r, logic [2:0] i);
    logic [2:0] o;
    if (r.interleave) begin
      o = r.col[2:0] ^ i;
    end else begin
      o = {r.col[2] ^ i[2], r.col[1:0] + i[1:0]};
    end
    return {r.col[9:3], o};
  endfunction

  always_comb begin
    next_s = s;
    next_s.beat.valid = 1'b0;
    next_s.beat.last = 1'b0;
    if (s.busy) begin
      next_s.beat.valid = 1'b1; // R02
      next_s.beat.write = s.cur.write;
      next_s.beat.bank = s.cur.bank;
      next_s.beat.col_even = col_of(s.cur, s.idx); // R03
      next_s.beat.col_odd = col_of(s.cur, s.idx + 3'h1);
      next_s.beat.last = s.cur.bc4 ? (s.idx == 3'h2) : (s.idx == 3'h6); // R03
      next_s.idx = s.idx + 3'h2;
      if (next_s.beat.last) begin
        next_s.busy = 1'b0;
      end
    end
    if (start) begin
      next_s.cur = req;
      next_s.idx = 3'h0;
      next_s.busy = 1'b1;
    end
  end

  always_ff @(posedge ck or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign beat = s.beat;
endmodule

/* hdl/ddr4_device.sv */
// device core: command decode and bank state on the link clock,
// software registers on the system clock, handshakes between the two
// assumes: pins are synchronous to ck; ctrl is changed only while the link is idle
`timescale 1ns/100ps

// Function
// R01: x4/x8 use 4 groups of 4 banks; x16 uses 2 groups of 4.
// R02: two data words move per link clock; eight words per access.
// R03: bursts start at the column and run eight, or four when chopped.
// R04: controller opens a row before reading or writing that bank.
// R05: activate takes group from bg (bg0 on x16), bank from ba, row from addr.
// R06: read or write takes column from addr; addr 10 asks auto precharge.
// R07: with on-the-fly mode set, addr 12 picks burst of four or eight.
// R08: controller uses no-operation only around max power saving or gear-down.
// R09: reset clears gear-down and per-device addressing bits of mode register 3.
// R10: reset clears max power saving and cs latency of mode register 4.
// R11: reset clears the parity latency field of mode register 5.
// R12: reset clears hard and soft repair bits of mode register 4.
// R13: controller holds reset low through ramp, then the minimum pulse width.
// R14: controller holds boundary scan enable low 700 us after supplies settle.
// R15: controller drops clock enable at least 10 ns before reset release.
// R16: controller starts initialization within 3 seconds of reset release.
// R17: clock runs 10 ns or 5 periods before clock enable; deselect then.
// R18: controller waits reset exit time before the first mode register set.
// R19: controller runs long calibration, then waits lock and calibration times.
module ddr4_device #(
  parameter int XPR_CYCLES = `XPR_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic ck,
  input ddr4_pkg::link_pins_t pins,
  output ddr4_pkg::beat_t beat,
  output logic ready
);
  import ddr4_pkg::*;

  // ------------------------------------------------------------------
  // link clock domain state
  // ------------------------------------------------------------------
  typedef struct packed {
    init_state_t st;
    logic [2:0] xpr_cnt;
    logic [7:0][13:0] mr;
    logic [15:0] open;
    logic [15:0][17:0] row;
    logic [15:0] bursts;
    logic [2:0] err_tgl;
    logic snap_tgl;
    snap_t snap;
    logic start;
    burst_req_t req;
    logic ready;
  } link_state_t;

  // ------------------------------------------------------------------
  // system clock domain state
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] ctrl;
    logic [2:0] err;
    logic [2:0] err_seen;
    logic req_seen;
    snap_t snap;
    logic [31:0] rdata;
  } sys_state_t;

  link_state_t l;
  link_state_t next_l;
  sys_state_t c;
  sys_state_t next_c;

  logic ck_rst_n;
  logic [2:0] ctrl_ck;
  logic ack_ck;
  logic req_clk;
  logic [2:0] err_clk;

  // ------------------------------------------------------------------
  // crossings
  // ------------------------------------------------------------------
  // reset asserts at once on ck and releases two ck edges later
  cdc_sync #(.W(1)) u_ck_rst (
    .clk(ck),
    .rst_n(rst_n),
    .d(1'b1),
    .q(ck_rst_n)
  );

  // ctrl is quasi-static; bits may land one ck apart if changed mid-traffic
  cdc_sync #(.W(3)) u_ctrl (
    .clk(ck),
    .rst_n(ck_rst_n),
    .d(c.ctrl),
    .q(ctrl_ck)
  );

  cdc_sync #(.W(1)) u_ack (
    .clk(ck),
    .rst_n(ck_rst_n),
    .d(c.req_seen),
    .q(ack_ck)
  );

  cdc_sync #(.W(1)) u_req (
    .clk(clk),
    .rst_n(rst_n),
    .d(l.snap_tgl),
    .q(req_clk)
  );

  // each error bit is its own toggle, so bits may safely arrive apart
  cdc_sync #(.W(3)) u_err (
    .clk(clk),
    .rst_n(rst_n),
    .d(l.err_tgl),
    .q(err_clk)
  );

  // ------------------------------------------------------------------
  // command decode on the link clock
  // ------------------------------------------------------------------
  always_comb begin
    logic [3:0] bank;
    logic [2:0] mr_sel;
    logic [2:0] cmd;
    logic live;
    logic check;
    logic [1:0] bl;
    bank = '0;
    mr_sel = '0;
    cmd = '0;
    live = 1'b0;
    check = 1'b0;
    bl = '0;
    next_l = l;
    next_l.start = 1'b0;

    check = ctrl_ck[`CTRL_CHECK_BIT];
    if (org_t'(ctrl_ck[1:0]) == ORG_X16) begin
      bank = {1'b0, pins.bg[0], pins.ba}; // R01 R05
    end else begin
      bank = {pins.bg, pins.ba}; // R01 R05
    end
    mr_sel = {pins.bg[0], pins.ba};
    cmd = pins.addr[16:14];
    bl = l.mr[0][`MR0_BL_LSB +: 2];

    case (l.st)
      INIT_WAIT_CKE: begin
        if (pins.cke) begin
          next_l.st = INIT_XPR;
          next_l.xpr_cnt = 3'h0;
        end
      end
      INIT_XPR: begin
        next_l.xpr_cnt = l.xpr_cnt + 3'h1;
        if (l.xpr_cnt == 3'(XPR_CYCLES - 1)) begin
          next_l.st = INIT_READY;
        end
        // a mode register set inside the exit time is flagged, still stored
        if (!pins.cs_n && pins.act_n && cmd == `CMD_MRS) begin
          next_l.mr[mr_sel] = pins.addr[13:0];
          if (check) begin
            next_l.err_tgl[2] = ~l.err_tgl[2]; // R18
          end
        end
      end
      INIT_READY: begin
        live = pins.cke && !pins.cs_n;
      end
      default: begin
        next_l.st = INIT_WAIT_CKE;
      end
    endcase

    if (live && !pins.act_n) begin
      next_l.open[bank] = 1'b1; // R05
      next_l.row[bank] = pins.addr; // R05
    end else if (live) begin
      case (cmd)
        `CMD_MRS: begin
          next_l.mr[mr_sel] = pins.addr[13:0];
        end
        `CMD_PRE: begin
          if (pins.addr[`ADDR_AP_BIT]) begin
            next_l.open = '0;
          end else begin
            next_l.open[bank] = 1'b0;
          end
        end
        `CMD_RD, `CMD_WR: begin
          if (!l.open[bank]) begin
            // access to a closed bank is dropped
            if (check) begin
              next_l.err_tgl[0] = ~l.err_tgl[0]; // R04
            end
          end else begin
            next_l.start = 1'b1;
            next_l.req.write = (cmd == `CMD_WR);
            next_l.req.bank = bank;
            next_l.req.col = pins.addr[9:0]; // R06
            next_l.req.interleave = l.mr[0][`MR0_BT_BIT]; // R03
            if (bl == `BL_OTF) begin
              next_l.req.bc4 = !pins.addr[`ADDR_BL8_BIT]; // R07
            end else begin
              next_l.req.bc4 = (bl == `BL_FIX4); // R03
            end
            next_l.bursts = l.bursts + 16'h0001;
            if (pins.addr[`ADDR_AP_BIT]) begin
              next_l.open[bank] = 1'b0; // R06
            end
          end
        end
        `CMD_NOP: begin
          // only legal around max power saving or gear-down
          if (check && !l.mr[4][`MR4_MAXPD_BIT] && !l.mr[3][`MR3_GEARDOWN_BIT]) begin
            next_l.err_tgl[1] = ~l.err_tgl[1]; // R08
          end
        end
        default: begin
          next_l.open = next_l.open;
        end
      endcase
    end

    next_l.ready = (next_l.st == INIT_READY);

    // the snapshot stays frozen until the system side has echoed the toggle
    if (ack_ck == l.snap_tgl) begin
      next_l.snap.ready = l.ready;
      next_l.snap.open_mask = l.open;
      next_l.snap.mr3 = l.mr[3];
      next_l.snap.mr4 = l.mr[4];
      next_l.snap.mr5 = l.mr[5];
      next_l.snap.bursts = l.bursts;
      next_l.snap_tgl = ~l.snap_tgl;
    end
  end

  always_ff @(posedge ck or negedge ck_rst_n) begin
    if (!ck_rst_n) begin
      l <= '0;
      l.st <= INIT_WAIT_CKE;
      l.mr <= {8{`MR_RESET}}; // R09 R10 R11 R12
    end else begin
      l <= next_l;
    end
  end

  burst_gen u_burst (
    .ck(ck),
    .rst_n(ck_rst_n),
    .start(l.start),
    .req(l.req),
    .beat(beat)
  );

  assign ready = l.ready;

  // ------------------------------------------------------------------
  // register port on the system clock
  // ------------------------------------------------------------------
  always_comb begin
    logic [2:0] ev;
    logic [2:0] clr;
    ev = '0;
    clr = '0;
    next_c = c;
    next_c.rdata = 32'h0000_0000;

    ev = err_clk ^ c.err_seen;
    next_c.err_seen = err_clk;
    if (req_clk != c.req_seen) begin
      next_c.snap = l.snap;
      next_c.req_seen = req_clk;
    end

    if (wr) begin
      if (addr == `OFF_CTRL) begin
        next_c.ctrl = wdata[2:0];
      end else if (addr == `OFF_STATUS) begin
        clr = wdata[`ST_ERR_LSB +: 3];
      end
    end
    // a new event in the clearing cycle survives
    next_c.err = (c.err & ~clr) | ev;

    if (rd) begin
      if (addr == `OFF_CTRL) begin
        next_c.rdata = {29'h0, c.ctrl};
      end else if (addr == `OFF_STATUS) begin
        next_c.rdata = {c.snap.open_mask, 12'h000, c.err, c.snap.ready};
      end else if (addr == `OFF_MR3) begin
        next_c.rdata = {18'h00000, c.snap.mr3};
      end else if (addr == `OFF_MR4) begin
        next_c.rdata = {18'h00000, c.snap.mr4};
      end else if (addr == `OFF_MR5) begin
        next_c.rdata = {18'h00000, c.snap.mr5};
      end else if (addr == `OFF_BURSTS) begin
        next_c.rdata = {16'h0000, c.snap.bursts};
      end else begin
        next_c.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      c <= '0;
      c.ctrl <= `CTRL_RESET;
      c.snap.mr3 <= `MR_RESET;
      c.snap.mr4 <= `MR_RESET;
      c.snap.mr5 <= `MR_RESET;
    end else begin
      c <= next_c;
    end
  end

  assign rdata = c.rdata;
endmodule

/* verif/ddr4_device_assertions.sv */
// checker on the device core ports
// assumes: bound to each ddr4_device
`timescale 1ns/100ps
module ddr4_device_assertions #(
  parameter int XPR_CYCLES = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic ck,
  input ddr4_pkg::link_pins_t pins,
  input ddr4_pkg::beat_t beat,
  input wire logic ready
);
  import ddr4_pkg::*;
  `include "ddr4_regs.svh"
  // ----
  // link side
  // ----
  a_pair_cols: assert property (@(posedge ck) disable iff (!rst_n)
    beat.valid |-> beat.col_odd[9:2] == beat.col_even[9:2]) else $error("beat columns split");
  a_two_words: assert property (@(posedge ck) disable iff (!rst_n)
    $rose(beat.valid) |-> !beat.last ##1 beat.valid) else $error("burst too short");
  a_burst_run: assert property (@(posedge ck) disable iff (!rst_n)
    beat.valid && !beat.last |=> beat.valid) else $error("burst broke off");
  a_burst_steady: assert property (@(posedge ck) disable iff (!rst_n)
    beat.valid && !beat.last |=> $stable(beat.bank) && $stable(beat.write))
    else $error("burst changed bank");
  a_no_early: assert property (@(posedge ck) disable iff (!rst_n)
    !ready |-> !beat.valid) else $error("beat before init");
  // ----
  // mode register defaults, read before the link is up
  // ----
  a_mr3_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd) && $past(addr) == `OFF_MR3 && !$past(ready) |-> rdata[4:3] == 2'h0)
    else $error("mode 3 not cleared");
  a_mr4_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd) && $past(addr) == `OFF_MR4 && !$past(ready) |-> {rdata[13], rdata[8:5],
    rdata[1]} == 6'h00) else $error("mode 4 not cleared");
  a_mr5_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $past(rd) && $past(addr) == `OFF_MR5 && !$past(ready) |-> rdata[2:0] == 3'h0)
    else $error("mode 5 not cleared");
endmodule
bind ddr4_device ddr4_device_assertions #(.XPR_CYCLES(XPR_CYCLES)) chk (.clk(clk),
  .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .ck(ck),
  .pins(pins), .beat(beat), .ready(ready));

/* verif/ddr4_ctrl_model.sv */
// controller stand-in driving the command pins
// assumes: ck runs free; the bench calls its tasks
`timescale 1ns/100ps
module ddr4_ctrl_model (
  input wire logic ck,
  output ddr4_pkg::link_pins_t pins
);
  import ddr4_pkg::*;
  // this core has no boundary_scan_enable input; it counts as held low throughout
  // clock enable low from power-up until woken
  initial pins = '{cke: 1'b0, cs_n: 1'b1, act_n: 1'b1, bg: 2'h0, ba: 2'h0, addr: 18'h0};
  // ----
  // deselect; lines scrambled so nothing stale looks valid
  // ----
  task automatic set_cke(input logic on);
    @(posedge ck);
    pins <= '{cke: on, cs_n: 1'b1, act_n: 1'b1, bg: ~pins.bg, ba: ~pins.ba, addr: ~pins.addr};
  endtask
  task automatic issue(input logic act, input logic [1:0] bg, input logic [1:0] ba,
      input logic [17:0] a);
    @(posedge ck);
    pins <= '{cke: 1'b1, cs_n: 1'b0, act_n: ~act, bg: bg, ba: ba, addr: a};
    set_cke(1'b1);
  endtask
endmodule

/* verif/test_ddr4_device.sv */
// self-checking bench for the device core
// assumes: design and controller model compiled first
`timescale 1ns/100ps
module test_ddr4_device;
  import ddr4_pkg::*;
  `include "ddr4_regs.svh"
  logic clk, rst_n, ck, wr, rd, ready;
  logic [7:0] addr;
  logic [31:0] wdata, rdata, v;
  link_pins_t pins;
  beat_t beat;
  int fails, checked;
  ddr4_device #(.XPR_CYCLES(5)) dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .ck(ck), .pins(pins), .beat(beat), .ready(ready));
  ddr4_ctrl_model ctl (.ck(ck), .pins(pins));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    ck = 1'b0;
    #7;
    forever #24 ck = ~ck;
  end
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
    check(v, exp);
  endtask
  // snapshots lag the link by a few cycles of both clocks
  task automatic settle();
    repeat (25) @(posedge clk);
  endtask
  function automatic logic [17:0] cmd_a(input logic [2:0] c, input logic [13:0] low);
    return {1'b0, c, low};
  endfunction
  function automatic logic [9:0] col_at(input logic [9:0] s, input int i, input logic il);
    logic [2:0] x;
    x = il ? s[2:0] ^ 3'(i) : {s[2] ^ i[2], s[1:0] + 2'(i)};
    return {s[9:3], x};
  endfunction
  task automatic expect_burst(input int nb, input logic il, input logic w);
    beat_t e;
    int n;
    n = 0;
    do begin
      @(negedge ck);
      n++;
    end while (beat.valid !== 1'b1 && n < 8);
    for (int k = 0; k < nb; k++) begin
      e = '{valid: 1'b1, write: w, last: k == nb - 1, bank: 4'h0,
        col_even: col_at(10'h005, 2 * k, il), col_odd: col_at(10'h005, 2 * k + 1, il)};
      check(32'(beat), 32'(e));
      @(negedge ck);
    end
    check(32'(beat.valid), 32'h0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_defaults();
    reg_rd(`OFF_CTRL, 32'h4);
    reg_rd(`OFF_STATUS, 32'h0);
    reg_wr(`OFF_MR4, 32'hFFFF);
    reg_wr(8'h20, 32'hFFFF);
    reg_rd(`OFF_MR3, 32'h0);
    reg_rd(`OFF_MR4, 32'h0);
    reg_rd(`OFF_MR5, 32'h0);
    reg_rd(8'h20, 32'h0);
    $display("defaults done");
  endtask
  task automatic t_init();
    int n;
    n = 0;
    ctl.set_cke(1'b1);
    while (ready !== 1'b1 && n < 40) begin
      @(negedge ck);
      n++;
    end
    check(32'(n >= 5 && n < 40), 32'h1);
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_ZQ, 14'h0400));
    settle();
    reg_rd(`OFF_STATUS, 32'h1);
    $display("init done");
  endtask
  task automatic t_bursts();
    logic [13:0] mode [4] = '{14'h0000, 14'h0001, 14'h0001, 14'h000A};
    logic [13:0] sel [4] = '{14'h0005, 14'h1005, 14'h0005, 14'h1005};
    int beats [4] = '{4, 4, 2, 2};
    ctl.issue(1'b1, 2'h0, 2'h0, 18'h01234);
    for (int i = 0; i < 4; i++) begin
      ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_MRS, mode[i]));
      ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(i[0] ? `CMD_WR : `CMD_RD, sel[i]));
      expect_burst(beats[i], mode[i][3], i[0]);
    end
    settle();
    reg_rd(`OFF_BURSTS, 32'h4);
    $display("bursts done");
  endtask
  task automatic t_autopre();
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_RD, 14'h0405));
    expect_burst(2, 1'b1, 1'b0);
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_RD, 14'h0005));
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_NOP, 14'h0000));
    settle();
    reg_rd(`OFF_STATUS, 32'h7);
    reg_wr(`OFF_STATUS, 32'h6);
    reg_rd(`OFF_BURSTS, 32'h5);
    reg_rd(`OFF_STATUS, 32'h1);
    $display("auto precharge done");
  endtask
  task automatic t_org();
    reg_wr(`OFF_CTRL, 32'h6);
    settle();
    ctl.issue(1'b1, 2'h3, 2'h2, 18'h00010);
    settle();
    reg_rd(`OFF_STATUS, 32'h0040_0001);
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_PRE, 14'h0400));
    reg_wr(`OFF_CTRL, 32'h5);
    settle();
    ctl.issue(1'b1, 2'h3, 2'h1, 18'h00010);
    settle();
    reg_rd(`OFF_STATUS, 32'h2000_0001);
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_PRE, 14'h0400));
    reg_wr(`OFF_CTRL, 32'h4);
    $display("organisation done");
  endtask
  task automatic t_reset2();
    ctl.issue(1'b0, 2'h0, 2'h3, cmd_a(`CMD_MRS, 14'h0018));
    ctl.issue(1'b0, 2'h1, 2'h0, cmd_a(`CMD_MRS, 14'h20E2));
    ctl.issue(1'b0, 2'h1, 2'h1, cmd_a(`CMD_MRS, 14'h0007));
    settle();
    reg_rd(`OFF_MR4, 32'h20E2);
    ctl.set_cke(1'b0);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    $display("second reset done");
    t_defaults();
    // a mode register set right after waking lands inside the exit time
    ctl.set_cke(1'b1);
    ctl.issue(1'b0, 2'h0, 2'h0, cmd_a(`CMD_MRS, 14'h0000));
    settle();
    reg_rd(`OFF_STATUS, 32'h9);
  endtask
  initial begin
    rst_n = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    fails = 0;
    checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_init();
    t_bursts();
    t_autopre();
    t_org();
    t_reset2();
    test_done();
  end
  initial begin
    #1_000_000;
    fails++;
    test_done();
  end
endmodule
